/* rtl/pulse_output_feedback_status.sv */
// module: two-channel pulse output with ahb-lite feedback status registers
// Functional notes
// - load_ack_toggle flips per successful load action
// - parameterized_flag bit 4 shows readiness
// - soft_enable_echo mirrors software enable bit
// - sequence_running high while sequence active
// - out_a_level reports pulse output level
// - out_b_level reports auxiliary output level
// - in0_level reports digital input level
// - sequence_tally increments per completed sequence
// - tally wraps 0..1 software, 0..15 hardware
// - undefined bytes and status bits read zero; control bits 7:4 read back as written
// - channel 1 status bytes and control 1 writes only in two-channel mode; control 1 always reads back
// - hardware mode: input low during the delay phase clears, high issues enable
// - start on filtered rising edge, enabled
// - pulse output high for pulse duration
`timescale 1ns/10ps
`default_nettype none
module pulse_output_feedback_status
  import pulse_fb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  in0_pin,
  output logic      [1:0]  pulse_out_a,
  output logic      [1:0]  aux_out_b
);

  // ----------------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl_r [2];
  logic [1:0]  config_r;
  logic        wr_pend_r;
  logic [7:0]  wr_idx_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  wire        addr_ok   = hsel && hready && htrans[1];
  wire [7:0]  addr_idx  = haddr[9:2];
  wire        two_ch    = config_r[CFG_TWO_CH];
  wire        params_ok = config_r[CFG_PARAM];

  // ----------------------------------------------------------------------------
  // per-channel sequencer
  // ----------------------------------------------------------------------------
  logic [7:0]  stat_ld   [2];
  logic [7:0]  stat_pin  [2];
  logic [7:0]  stat_tal  [2];
  logic [1:0]  load_hit;
  logic [1:0]  seq_run;
  logic [1:0]  out_a_q;

  assign load_hit[0] = wr_pend_r && (wr_idx_r == IDX_CTRL0) && hwdata[CTL_LOAD_STB];
  assign load_hit[1] = wr_pend_r && (wr_idx_r == IDX_CTRL1) && hwdata[CTL_LOAD_STB] && two_ch;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      chan_ctl_type  ctl;
      seq_state_type st_r;
      logic [2:0]    sync_r;
      logic          filt_r;
      logic          filt_d_r;
      logic [7:0]    dly_cnt_r;
      logic [15:0]   pls_cnt_r;
      logic [3:0]    tally_r;
      logic          ack_r;
      logic          soft_d_r;
      logic          hw_mode_r;

      // one assignment keeps the struct a single-driver variable
      assign ctl = {ctrl_r[ch][CTL_SOFT_EN], ctrl_r[ch][CTL_HW_FUNC], ctrl_r[ch][CTL_AUX_B],
                    ctrl_r[ch][CTL_DELAY_LSB +: 8], ctrl_r[ch][CTL_PULSE_LSB +: 16]};

      // level once second and third stage agree
      wire agree   = sync_r[1] == sync_r[2];
      wire hw_rise = filt_r && !filt_d_r;
      wire start_hw = ctl.hw_func && ctl.soft_en && hw_rise;
      wire start_sw = !ctl.hw_func && ctl.soft_en && !soft_d_r;
      wire active   = st_r != SEQ_IDLE;
      wire done     = (st_r == SEQ_PULSE) && (pls_cnt_r <= 16'h0001);
      wire [3:0] tmax = hw_mode_r ? TALLY_MAX_HW : TALLY_MAX_SW;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_r   <= 3'h0;
          filt_r   <= 1'b0;
          filt_d_r <= 1'b0;
          soft_d_r <= 1'b0;
        end else begin
          sync_r   <= {sync_r[1:0], in0_pin[ch]};
          filt_d_r <= filt_r;
          soft_d_r <= ctl.soft_en;
          if (agree) begin
            filt_r <= sync_r[2];
          end
        end
      end

      // input delay then pulse; pulse length
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_r      <= SEQ_IDLE;
          dly_cnt_r <= 8'h00;
          pls_cnt_r <= 16'h0000;
          hw_mode_r <= 1'b0;
        end else if (!ctl.soft_en) begin
          // dropping the software enable cancels at once
          st_r <= SEQ_IDLE;
        end else begin
          case (st_r)
            SEQ_IDLE: begin
              if (start_hw || start_sw) begin
                hw_mode_r <= ctl.hw_func;
                dly_cnt_r <= ctl.delay;
                pls_cnt_r <= ctl.pulse_len;
                st_r      <= (ctl.delay == 8'h00) ? SEQ_PULSE : SEQ_DELAY;
              end
            end
            SEQ_DELAY: begin
              // hardware enable must stay high across the delay
              if (hw_mode_r && !filt_r) begin
                st_r <= SEQ_IDLE;
              end else if (dly_cnt_r <= 8'h01) begin
                st_r <= SEQ_PULSE;
              end else begin
                dly_cnt_r <= dly_cnt_r - 8'h01;
              end
            end
            SEQ_PULSE: begin
              if (done) begin
                st_r <= SEQ_IDLE;
              end else begin
                pls_cnt_r <= pls_cnt_r - 16'h0001;
              end
            end
            default: st_r <= SEQ_IDLE;
          endcase
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tally_r <= 4'h0;
          ack_r   <= 1'b0;
        end else begin
          if (done && ctl.soft_en) begin
            tally_r <= (tally_r >= tmax) ? 4'h0 : tally_r + 4'h1;
          end
          if (load_hit[ch] && params_ok) begin
            ack_r <= ~ack_r;
          end
        end
      end

      // output high only in pulse phase
      assign out_a_q[ch] = (st_r == SEQ_PULSE) && ctl.soft_en;
      assign seq_run[ch] = active;

      assign stat_ld[ch] = 8'(({7'h00, ack_r} << BIT_LOAD_ACK)
                          | ({7'h00, params_ok} << BIT_PARAM)
                          | ({7'h00, ctl.soft_en} << BIT_SOFT_ECHO));
      assign stat_pin[ch] = 8'(({7'h00, active} << BIT_RUNNING)
                          | ({7'h00, pulse_out_a[ch]} << BIT_OUT_A)
                          | ({7'h00, aux_out_b[ch]} << BIT_OUT_B)
                          | ({7'h00, filt_r} << BIT_IN0));
      assign stat_tal[ch] = {4'h0, tally_r};
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  // unmapped reads zero; channel 1 status bytes gated, control 1 is not
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (addr_idx)
      IDX_CH0_LOAD_READY: rdata_nxt = {24'h0, stat_ld[0]};
      IDX_CH0_RUN_PIN:    rdata_nxt = {24'h0, stat_pin[0]};
      IDX_CH0_TALLY:      rdata_nxt = {24'h0, stat_tal[0]};
      IDX_CH1_LOAD_READY: rdata_nxt = two_ch ? {24'h0, stat_ld[1]} : 32'h0;
      IDX_CH1_PIN:        rdata_nxt = two_ch ? {24'h0, stat_pin[1]} : 32'h0;
      IDX_CH1_TALLY:      rdata_nxt = two_ch ? {24'h0, stat_tal[1]} : 32'h0;
      IDX_CTRL0:          rdata_nxt = ctrl_r[0] & ~(32'h1 << CTL_LOAD_STB);
      IDX_CTRL1:          rdata_nxt = ctrl_r[1] & ~(32'h1 << CTL_LOAD_STB);
      IDX_CONFIG:         rdata_nxt = {30'h0, config_r};
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  // registered snapshot taken at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_idx_r  <= addr_idx;
      if (addr_ok && !hwrite) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r[0] <= CTRL_RESET;
      ctrl_r[1] <= CTRL_RESET;
      config_r  <= CONFIG_RESET;
    end else if (wr_pend_r) begin
      if (wr_idx_r == IDX_CTRL0) ctrl_r[0] <= hwdata;
      if (wr_idx_r == IDX_CTRL1 && two_ch) ctrl_r[1] <= hwdata;
      if (wr_idx_r == IDX_CONFIG) config_r <= hwdata[1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // outputs from flip-flops; hreadyout and hresp tied constant
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_out_a <= 2'h0;
      aux_out_b   <= 2'h0;
    end else begin
      pulse_out_a <= out_a_q;
      aux_out_b   <= {ctrl_r[1][CTL_AUX_B], ctrl_r[0][CTL_AUX_B]};
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_echo_soft: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_ld[0][BIT_SOFT_ECHO] == ctrl_r[0][CTL_SOFT_EN])
    else $error("enable echo differs from control");
  chk_ack_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    (load_hit[0] && params_ok) |=> (stat_ld[0][BIT_LOAD_ACK] != $past(stat_ld[0][BIT_LOAD_ACK])))
    else $error("load ack did not toggle");
  chk_param_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_ld[0][BIT_PARAM] == config_r[CFG_PARAM])
    else $error("parameterized flag wrong");
  chk_run_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[0][CTL_SOFT_EN] |=> !seq_run[0])
    else $error("sequence still running after disable");
  chk_out_a_level: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_pin[0][BIT_OUT_A] == pulse_out_a[0])
    else $error("output a level misreported");
  chk_pulse_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    out_a_q[0] |=> pulse_out_a[0])
    else $error("pulse output not driven");
  chk_tally_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    !g_ch[0].hw_mode_r |-> stat_tal[0] <= 8'h01)
    else $error("software tally beyond one");
  chk_ch1_hidden: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && !two_ch && addr_idx == IDX_CH1_PIN) |=> hrdata == 32'h0)
    else $error("channel 1 visible in single mode");
  chk_out_b_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> aux_out_b[0] == $past(ctrl_r[0][CTL_AUX_B]))
    else $error("output b does not follow control");
  chk_in0_filter: assert property (@(posedge hclk) disable iff (!hresetn)
    (g_ch[0].sync_r[1] == g_ch[0].sync_r[2]) |=> g_ch[0].filt_r == $past(g_ch[0].sync_r[2]))
    else $error("input level not taken after agreement");
  chk_tally_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (g_ch[0].done && ctrl_r[0][CTL_SOFT_EN]) |=> stat_tal[0] != $past(stat_tal[0]))
    else $error("tally did not advance on completion");
  chk_hw_start: assert property (@(posedge hclk) disable iff (!hresetn)
    g_ch[0].start_hw |=> seq_run[0])
    else $error("hardware enable did not start a sequence");
  chk_start_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (g_ch[0].st_r == SEQ_IDLE && !ctrl_r[0][CTL_SOFT_EN]) |=> g_ch[0].st_r == SEQ_IDLE)
    else $error("sequence started without software enable");
  cov_hw_start: cover property (@(posedge hclk) g_ch[0].start_hw);
  cov_done: cover property (@(posedge hclk) g_ch[0].done);
  cov_sw_start: cover property (@(posedge hclk) g_ch[0].start_sw);
  cov_load: cover property (@(posedge hclk) load_hit[0] && params_ok);

endmodule : pulse_output_feedback_status
`default_nettype wire

/* rtl/pulse_fb_pkg.sv */
// package: register map, field positions, reset values and types for the pulse feedback block
package pulse_fb_pkg;

  // ----------------------------------------------------------------------------
  // register byte offsets (printed offsets not multiples of four: index * 4)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] IDX_CH0_LOAD_READY = 8'h01;
  localparam logic [7:0] IDX_CH0_RUN_PIN    = 8'h02;
  localparam logic [7:0] IDX_CH0_TALLY      = 8'h03;
  localparam logic [7:0] IDX_CH1_LOAD_READY = 8'h09;
  localparam logic [7:0] IDX_CH1_PIN        = 8'h0a;
  localparam logic [7:0] IDX_CH1_TALLY      = 8'h0b;
  localparam logic [7:0] IDX_CTRL0          = 8'h10;
  localparam logic [7:0] IDX_CTRL1          = 8'h11;
  localparam logic [7:0] IDX_CONFIG         = 8'h12;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int BIT_LOAD_ACK   = 2;
  localparam int BIT_PARAM      = 4;
  localparam int BIT_SOFT_ECHO  = 5;
  localparam int BIT_RUNNING    = 0;
  localparam int BIT_OUT_A      = 1;
  localparam int BIT_OUT_B      = 2;
  localparam int BIT_IN0        = 3;
  // control register fields (per channel)
  localparam int CTL_SOFT_EN    = 0;
  localparam int CTL_HW_FUNC    = 1;
  localparam int CTL_LOAD_STB   = 2;
  localparam int CTL_AUX_B      = 3;
  localparam int CTL_DELAY_LSB  = 8;
  localparam int CTL_PULSE_LSB  = 16;
  // config register fields
  localparam int CFG_PARAM      = 0;
  localparam int CFG_TWO_CH     = 1;

  // ----------------------------------------------------------------------------
  // values after reset and widths
  // ----------------------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [1:0]  CONFIG_RESET = 2'h2;
  localparam logic [3:0]  TALLY_MAX_SW = 4'h1;
  localparam logic [3:0]  TALLY_MAX_HW = 4'hf;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_DELAY = 3'b010,
    SEQ_PULSE = 3'b100
  } seq_state_type;

  typedef struct packed {
    logic        soft_en;
    logic        hw_func;
    logic        aux_b;
    logic [7:0]  delay;
    logic [15:0] pulse_len;
  } chan_ctl_type;

endpackage : pulse_fb_pkg

/* test/fb_reader.sv */
// ahb-lite master model standing in for the controller that reads feedback
`timescale 1ns/10ps
`default_nettype none
module fb_reader (
  input  wire logic        hclk,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // hsel stays up once set; idle htrans marks the gaps, so no double assignment
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : fb_reader
`default_nettype wire

/* test/pulse_output_feedback_status_tb.sv */
// self-checking bench for the pulse feedback status block
`timescale 1ns/10ps
`default_nettype none
module pulse_output_feedback_status_tb import pulse_fb_pkg::*;;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  in0_pin = 2'h0;
  logic        hsel, hwrite, hreadyout, hresp, seen_a;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0]  htrans, pulse_out_a, aux_out_b;
  logic [2:0]  hsize;
  int          fail_count = 0;
  int          tests_run = 0;
  int          hi_cnt = 0;
  int          base;
  always #10 hclk = ~hclk;
  always @(posedge hclk) if (pulse_out_a[0] === 1'b1) hi_cnt <= hi_cnt + 1;
  pulse_output_feedback_status uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .in0_pin(in0_pin), .pulse_out_a(pulse_out_a), .aux_out_b(aux_out_b));
  fb_reader host (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] idx);
    host.xfer(idx, 1'b0, 32'h0, rd_v);
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(idx, 1'b1, d, rd_v);
  endtask : wr
  // polls the running bit; a bounded count keeps a stuck flag from hanging
  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    do begin
      rd(IDX_CH0_RUN_PIN);
      seen_a = seen_a | rd_v[BIT_OUT_A];
      n++;
    end while (rd_v[BIT_RUNNING] !== lvl && n < 60);
    check({31'h0, rd_v[BIT_RUNNING]}, {31'h0, lvl});
  endtask : wait_run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rd(IDX_CONFIG);
    check(rd_v, 32'h2);
    rd(IDX_CH0_LOAD_READY);
    check(rd_v, 32'h0);
    rd(IDX_CH0_RUN_PIN);
    check(rd_v, 32'h0);
    rd(8'h05);
    check(rd_v, 32'h0);
    check({31'h0, hresp}, 32'h0);
    check({28'h0, pulse_out_a, aux_out_b}, 32'h0);
  endtask : t_reset
  task automatic t_load();
    wr(IDX_CONFIG, 32'h3);
    rd(IDX_CH0_LOAD_READY);
    check(rd_v, 32'h10);
    wr(IDX_CTRL0, 32'h4);
    rd(IDX_CH0_LOAD_READY);
    check(rd_v, 32'h14);
    wr(IDX_CTRL0, 32'h4);
    rd(IDX_CH0_LOAD_READY);
    check(rd_v, 32'h10);
    rd(IDX_CH1_LOAD_READY);
    check(rd_v, 32'h10);
    wr(IDX_CONFIG, 32'h1);
    rd(IDX_CH1_LOAD_READY);
    check(rd_v, 32'h0);
    rd(IDX_CH1_PIN);
    check(rd_v, 32'h0);
    wr(IDX_CONFIG, 32'h3);
  endtask : t_load
  task automatic t_soft();
    for (int i = 0; i < 2; i++) begin
      wr(IDX_CTRL0, 32'h0006_0800);
      base = hi_cnt;
      seen_a = 1'b0;
      wr(IDX_CTRL0, 32'h0006_0801);
      rd(IDX_CH0_LOAD_READY);
      check(rd_v, 32'h30);
      wait_run(1'b1);
      wait_run(1'b0);
      check({31'h0, seen_a}, 32'h1);
      check(32'(hi_cnt - base), 32'h6);
      rd(IDX_CH0_TALLY);
      check(rd_v, (i == 0) ? 32'h1 : 32'h0);
    end
  endtask : t_soft
  task automatic t_pins();
    wr(IDX_CTRL0, 32'h8);
    // the output flop lags the control write by one cycle
    @(posedge hclk);
    rd(IDX_CH0_RUN_PIN);
    check(rd_v, 32'h4);
    check({31'h0, aux_out_b[0]}, 32'h1);
    rd(IDX_CH0_LOAD_READY);
    check(rd_v, 32'h10);
    wr(IDX_CTRL0, 32'h0002_0302);
    base = hi_cnt;
    in0_pin <= 2'h1;
    repeat (20) @(posedge hclk);
    rd(IDX_CH0_RUN_PIN);
    check(rd_v, 32'h8);
    check(32'(hi_cnt - base), 32'h0);
    in0_pin <= 2'h0;
    repeat (6) @(posedge hclk);
  endtask : t_pins
  // sixteen hardware starts walk the tally through its full wrap
  task automatic t_hw();
    logic [3:0] t0;
    wr(IDX_CTRL0, 32'h0002_0303);
    rd(IDX_CH0_TALLY);
    t0 = rd_v[3:0];
    for (int i = 1; i <= 16; i++) begin
      base = hi_cnt;
      in0_pin <= 2'h1;
      wait_run(1'b1);
      wait_run(1'b0);
      in0_pin <= 2'h0;
      repeat (6) @(posedge hclk);
      check(32'(hi_cnt - base), 32'h2);
      rd(IDX_CH0_TALLY);
      check(rd_v, {28'h0, 4'(t0 + i)});
    end
  endtask : t_hw
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_load();
    t_soft();
    t_pins();
    t_hw();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    close_out();
  end
endmodule : pulse_output_feedback_status_tb
`default_nettype wire
